// file: rtl/codec_frame_sync_sequencer.sv
// frame sync sequencer of the serial codec interface, with its ahb-lite register slave
// Notes on behaviour
// - frame sync pin direction follows frame_sync_direction_bit in codec_control_reg.
// - in master mode frame sync is an input, resynchronised before edge detection.
// - word type 00 is single data mode, one sample per frame sync cycle.
// - word type 01 sends a control word then a conversion data word.
// - word type 10 sends a control word then two conversion data words.
// - word type 11 is stereo, left and right sample per frame sync cycle.
// - single data transfer starts on a rising edge of resynchronised frame sync.
// - wait first_bit_delay bit-clock cycles from rising edge to first bit.
// - after the delay, sample serial input, drive serial output, one bit per cycle.
// - after 16 or 32 bits per word_size_select, go idle and await next frame.
// - two-word mode runs two identical frames per sequence.
// - three-word mode runs three identical frames per sequence.
// - every multi-word frame is shaped like a single data frame.
// - in two-word mode the second word is conversion data after control.
// - bit clock is an input (master) when bit_clock_direction_bit is low.
// - transmit bits change on rising bit clock, or falling when tx_edge_select is high.
// - stereo left word while frame sync high, right while low, both edges used.
`timescale 1ns/10ps

module codec_frame_sync_sequencer
	import codec_seq_pkg::*;
(
	input  wire logic        hclk,              // subsystem clock, 25 MHz
	input  wire logic        hresetn,           // async reset, active low
	input  wire logic        clk_en,            // freezes bus and sequencer state while low; bit_clk synchronisers keep running
	input  wire logic        hsel,              // slave select
	input  wire logic [31:0] haddr,             // byte address
	input  wire logic [1:0]  htrans,            // transfer type
	input  wire logic        hwrite,            // write when high
	input  wire logic [2:0]  hsize,             // word transfers only
	input  wire logic [31:0] hwdata,            // write data
	input  wire logic        hready,            // bus ready in
	output logic             hreadyout,         // slave ready
	output logic [31:0]      hrdata,            // read data
	output logic             hresp,             // always okay
	input  wire logic        bit_clk,           // serial bit clock from codec
	input  wire logic        frame_sync_pin_i,  // frame sync level at pin
	output logic             frame_sync_pin_o,  // frame sync drive value
	output logic             frame_sync_pin_oe, // frame sync drive enable
	input  wire logic        serial_in_pin,     // serial data from codec
	output logic             serial_out_pin,    // serial data to codec
	output logic             bit_clk_oe         // bit clock drive enable
);

	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------
	// which kind of word occupies a slot of the sequence
	function automatic word_kind_e slot_kind(input word_type_e wt, input logic [1:0] slot);
		unique case (wt)
			wt_single:     return kind_data;
			wt_ctrl_data:  return (slot == 2'd0) ? kind_control : kind_data;
			wt_ctrl_data2: return (slot == 2'd0) ? kind_control : kind_data;
			wt_stereo:     return (slot == 2'd0) ? kind_left : kind_right;
		endcase
		return kind_data;
	endfunction
	// index of the last slot of a sequence
	function automatic logic [1:0] last_slot(input word_type_e wt);
		return (wt == wt_ctrl_data2) ? 2'd2 : ((wt == wt_single) ? 2'd0 : 2'd1);
	endfunction
	// ------------------------------------------------------------
	// bus slave and registers (hclk domain)
	// ------------------------------------------------------------
	logic        run_r, fsdir_r, wsize_r, scdir_r, tes_r;
	word_type_e  wt_r;
	logic [7:0]  delay_r;
	logic [31:0] tx_data_r, rx_data_r, hrdata_r;
	logic        rx_ready_r, ovr_r, cfg_tgl_r;
	word_kind_e  kind_r;
	logic        ph_wr_r, ph_rd_r, rd_wait_r;
	logic [7:0]  addr_r;
	logic        acc, wr_take, rd_take, done_evt;
	logic        dn_meta_r, dn_sync_r, dn_prev_r, busy_meta_r, busy_sync_r;
	// link-side values read by hclk logic after a handshake
	logic [31:0] rx_hold_l;
	word_kind_e  kind_hold_l;
	logic        done_tgl_l, busy_l;
	link_state_e state_r;
	assign acc     = clk_en & hsel & htrans[1] & hready;
	assign wr_take = clk_en & ph_wr_r;
	assign rd_take = clk_en & ph_rd_r & ~rd_wait_r;
	// reads take one wait state so a read right after a write sees the new value
	assign hreadyout = clk_en & (~ph_rd_r | rd_wait_r);
	assign hrdata    = hrdata_r;
	assign hresp     = HRESP_OKAY;
	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr_r   <= 1'b0;
			ph_rd_r   <= 1'b0;
			rd_wait_r <= 1'b0;
			addr_r    <= 8'h00;
		end else if (clk_en) begin
			ph_wr_r   <= acc & hwrite;
			ph_rd_r   <= acc & ~hwrite;
			rd_wait_r <= ph_rd_r & ~rd_wait_r;
			addr_r    <= acc ? haddr[7:0] : addr_r;
		end
	end

	// register writes; every config write raises a toggle for the link side
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wsize_r, wt_r, fsdir_r, run_r} <= CTRL_RST;
			{tes_r, scdir_r}                <= CLKCFG_RST;
			delay_r                         <= DELAY_RST;
			tx_data_r                       <= 32'h0000_0000;
			cfg_tgl_r                       <= 1'b0;
		end else if (wr_take) begin
			unique case (addr_r)
				CTRL_OFS: begin
					run_r     <= hwdata[CTRL_RUN_BIT];
					fsdir_r   <= hwdata[CTRL_FSDIR_BIT];
					wt_r      <= word_type_e'({hwdata[CTRL_WT_HI_BIT], hwdata[CTRL_WT_LO_BIT]});
					wsize_r   <= hwdata[CTRL_WSIZE_BIT];
					cfg_tgl_r <= ~cfg_tgl_r;
				end
				CLKCFG_OFS: begin
					scdir_r   <= hwdata[CLK_SCDIR_BIT];
					tes_r     <= hwdata[CLK_TES_BIT];
					cfg_tgl_r <= ~cfg_tgl_r;
				end
				FRAME_OFS: begin
					delay_r   <= hwdata[7:0];
					cfg_tgl_r <= ~cfg_tgl_r;
				end
				TXDATA_OFS: tx_data_r <= hwdata;
				default: ;
			endcase
		end
	end

	// read data, registered in the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_take) begin
			hrdata_r <= 32'h0000_0000;
			unique case (addr_r)
				CTRL_OFS:   hrdata_r[4:0] <= {wsize_r, wt_r, fsdir_r, run_r};
				CLKCFG_OFS: hrdata_r[1:0] <= {tes_r, scdir_r};
				FRAME_OFS:  hrdata_r[7:0] <= delay_r;
				TXDATA_OFS: hrdata_r      <= tx_data_r;
				RXDATA_OFS: hrdata_r      <= rx_data_r;
				STATUS_OFS: hrdata_r[4:0] <= {ovr_r, busy_sync_r, kind_r, rx_ready_r};
				default:    hrdata_r      <= 32'h0000_0000;
			endcase
		end
	end

	// word-done toggle and busy level from the link domain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dn_meta_r   <= 1'b0;
			dn_sync_r   <= 1'b0;
			dn_prev_r   <= 1'b0;
			busy_meta_r <= 1'b0;
			busy_sync_r <= 1'b0;
		end else if (clk_en) begin
			dn_meta_r   <= done_tgl_l;
			dn_sync_r   <= dn_meta_r;
			dn_prev_r   <= dn_sync_r;
			busy_meta_r <= busy_l;
			busy_sync_r <= busy_meta_r;
		end
	end
	assign done_evt = clk_en & (dn_sync_r ^ dn_prev_r);
	// received word capture; a new word wins over a clearing read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_data_r  <= 32'h0000_0000;
			kind_r     <= kind_data;
			rx_ready_r <= 1'b0;
			ovr_r      <= 1'b0;
		end else if (clk_en) begin
			if (done_evt) begin
				rx_data_r <= rx_hold_l;
				kind_r    <= kind_hold_l;
			end
			rx_ready_r <= done_evt | (rx_ready_r & ~(rd_take && addr_r == RXDATA_OFS));
			if (done_evt && rx_ready_r && !(rd_take && addr_r == RXDATA_OFS)) begin
				ovr_r <= 1'b1;
			end else if (wr_take && addr_r == STATUS_OFS && hwdata[STAT_OVR_BIT]) begin
				ovr_r <= 1'b0;
			end
		end
	end
	// pin directions; frame sync generation for slave mode is not built, so it drives low
	assign frame_sync_pin_oe = fsdir_r;
	assign frame_sync_pin_o  = 1'b0;
	assign bit_clk_oe        = scdir_r;
	// ------------------------------------------------------------
	// link logic (bit_clk domain)
	// ------------------------------------------------------------
	logic        fs_meta_r, fs_sync_r, fs_prev_r, fs_rise, fs_fall;
	logic        en_meta_r, en_l, cf_meta_r, cf_sync_r, cf_prev_r, cfg_take;
	logic        run_l, wsize_l, tes_l, master_l;
	word_type_e  wt_l;
	logic [7:0]  delay_l, dly_cnt_r;
	logic [4:0]  bit_cnt_r, bit_last;
	logic [1:0]  slot_r;
	logic [31:0] tx_shift_r, rx_shift_r, tx_load;
	logic        out_pos_r, out_neg_r, start_ok, word_end;

	// level synchronisers: frame sync pin, clock enable, config toggle
	always_ff @(posedge bit_clk or negedge hresetn) begin
		if (!hresetn) begin
			fs_meta_r <= 1'b0;
			fs_sync_r <= 1'b0;
			en_meta_r <= 1'b0;
			en_l      <= 1'b0;
			cf_meta_r <= 1'b0;
			cf_sync_r <= 1'b0;
		end else begin
			fs_meta_r <= frame_sync_pin_i;
			fs_sync_r <= fs_meta_r;
			en_meta_r <= clk_en;
			en_l      <= en_meta_r;
			cf_meta_r <= cfg_tgl_r;
			cf_sync_r <= cf_meta_r;
		end
	end

	// edges are taken only from the synchronised copy
	assign fs_rise  = fs_sync_r & ~fs_prev_r;
	assign fs_fall  = ~fs_sync_r & fs_prev_r;
	assign cfg_take = (cf_sync_r ^ cf_prev_r) & (state_r == st_idle);
	assign bit_last = wsize_l ? LAST_BIT_32 : LAST_BIT_16;
	assign word_end = (state_r == st_shift) & (bit_cnt_r == bit_last);
	assign start_ok = run_l & master_l & fs_rise;
	// a 16-bit word goes out from the top of the shifter
	assign tx_load  = wsize_l ? tx_data_r : {tx_data_r[15:0], 16'h0000};

	// config copy; taken only between words so a live word never changes shape
	always_ff @(posedge bit_clk or negedge hresetn) begin
		if (!hresetn) begin
			cf_prev_r <= 1'b0;
			run_l     <= CTRL_RST[CTRL_RUN_BIT];
			wsize_l   <= CTRL_RST[CTRL_WSIZE_BIT];
			wt_l      <= wt_single;
			delay_l   <= DELAY_RST;
			tes_l     <= CLKCFG_RST[CLK_TES_BIT];
			master_l  <= ~CLKCFG_RST[CLK_SCDIR_BIT];
		end else if (en_l && cfg_take) begin
			cf_prev_r <= cf_sync_r;
			run_l     <= run_r;
			wsize_l   <= wsize_r;
			wt_l      <= wt_r;
			delay_l   <= delay_r;
			tes_l     <= tes_r;
			master_l  <= ~scdir_r;
		end
	end

	// sequencer state machine
	always_ff @(posedge bit_clk or negedge hresetn) begin
		if (!hresetn) begin
			state_r   <= st_idle;
			fs_prev_r <= 1'b0;
			dly_cnt_r <= 8'h00;
			bit_cnt_r <= 5'h00;
			slot_r    <= 2'd0;
			busy_l    <= 1'b0;
		end else if (en_l) begin
			fs_prev_r <= fs_sync_r;
			busy_l    <= (state_r != st_idle); // a flop, so the crossing never sees decode glitches
			unique case (state_r)
				st_idle: begin
					// edges outside idle never reach here, so they are dropped
					if (cfg_take) begin
						slot_r <= 2'd0;
					end else if (start_ok) begin
						dly_cnt_r <= delay_l;
						bit_cnt_r <= 5'h00;
						state_r   <= (delay_l == 8'h00) ? st_shift : st_delay;
					end
				end
				st_delay: begin
					dly_cnt_r <= dly_cnt_r - 8'h01;
					if (dly_cnt_r == 8'h01) begin
						state_r <= st_shift;
					end
				end
				st_shift: begin
					bit_cnt_r <= bit_cnt_r + 5'h01;
					if (word_end) begin
						slot_r <= (slot_r == last_slot(wt_l)) ? 2'd0 : slot_r + 2'd1;
						// stereo right word starts on the falling edge
						state_r <= (wt_l == wt_stereo && slot_r == 2'd0) ? st_wait_fall : st_idle;
					end
				end
				st_wait_fall: begin
					if (!run_l) begin
						state_r <= st_idle;
					end else if (fs_fall) begin
						dly_cnt_r <= delay_l;
						bit_cnt_r <= 5'h00;
						state_r   <= (delay_l == 8'h00) ? st_shift : st_delay;
					end
				end
			endcase
		end
	end

	// shift registers; the transmit shifter is reloaded at each word start, the receive shifter is not
	always_ff @(posedge bit_clk or negedge hresetn) begin
		if (!hresetn) begin
			tx_shift_r <= 32'h0000_0000;
			rx_shift_r <= 32'h0000_0000;
			out_pos_r  <= 1'b0;
		end else if (en_l) begin
			if ((state_r == st_idle && start_ok) || (state_r == st_wait_fall && fs_fall && run_l)) begin
				tx_shift_r <= tx_load;
			end else if (state_r == st_shift) begin
				out_pos_r  <= tx_shift_r[31];
				tx_shift_r <= {tx_shift_r[30:0], 1'b0};
				rx_shift_r <= {rx_shift_r[30:0], serial_in_pin};
			end
		end
	end

	// finished word handed to hclk by a toggle; the held word stays put for a whole word time
	always_ff @(posedge bit_clk or negedge hresetn) begin
		if (!hresetn) begin
			done_tgl_l  <= 1'b0;
			rx_hold_l   <= 32'h0000_0000;
			kind_hold_l <= kind_data;
		end else if (en_l && word_end) begin
			done_tgl_l  <= ~done_tgl_l;
			rx_hold_l   <= {rx_shift_r[30:0], serial_in_pin};
			kind_hold_l <= slot_kind(wt_l, slot_r);
		end
	end

	// half-cycle later copy for the falling-edge transmit option
	always_ff @(negedge bit_clk or negedge hresetn) begin
		if (!hresetn) begin
			out_neg_r <= 1'b0;
		end else begin
			out_neg_r <= out_pos_r;
		end
	end
	assign serial_out_pin = tes_l ? out_neg_r : out_pos_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_start_on_rise: assert property (@(posedge bit_clk) disable iff (!hresetn)
		(en_l && state_r == st_idle && !cfg_take && start_ok) |=> (state_r == st_delay || state_r == st_shift))
		else $error("rising frame sync did not start a word");
	a_idle_holds: assert property (@(posedge bit_clk) disable iff (!hresetn)
		(en_l && state_r == st_idle && !fs_rise) |=> state_r == st_idle)
		else $error("word started without a rising frame sync");
	a_master_only: assert property (@(posedge bit_clk) disable iff (!hresetn)
		(state_r == st_idle && !master_l) |=> state_r == st_idle)
		else $error("word started while bit clock is an output");
	a_delay_end: assert property (@(posedge bit_clk) disable iff (!hresetn)
		(en_l && state_r == st_delay && dly_cnt_r == 8'h02) ##1 en_l |=> state_r == st_shift)
		else $error("first bit not reached after the programmed delay");
	a_delay_zero: assert property (@(posedge bit_clk) disable iff (!hresetn)
		(en_l && state_r == st_idle && !cfg_take && start_ok && delay_l == 8'h00) |=> state_r == st_shift)
		else $error("zero delay did not shift at once");
	a_word_busy: assert property (@(posedge bit_clk) disable iff (!hresetn)
		(en_l && state_r == st_shift && !word_end) |=> state_r == st_shift)
		else $error("word cut short by a frame sync edge");
	a_word_done: assert property (@(posedge bit_clk) disable iff (!hresetn)
		(en_l && word_end) |=> (state_r != st_shift && done_tgl_l != $past(done_tgl_l)))
		else $error("word end not reported or shifting went on");
	a_tx_bit_order: assert property (@(posedge bit_clk) disable iff (!hresetn)
		(en_l && state_r == st_shift) |=> (out_pos_r == $past(tx_shift_r[31]) && rx_shift_r[0] == $past(serial_in_pin)))
		else $error("serial bit not moved in this bit clock cycle");
	a_stereo_right: assert property (@(posedge bit_clk) disable iff (!hresetn)
		(en_l && word_end && wt_l == wt_stereo && slot_r == 2'd0) |=> state_r == st_wait_fall)
		else $error("left word not followed by wait for falling frame sync");
	a_three_slots: assert property (@(posedge bit_clk) disable iff (!hresetn)
		(en_l && word_end && wt_l == wt_ctrl_data2 && slot_r == 2'd1) |=> slot_r == 2'd2)
		else $error("three-word sequence skipped a slot");
	a_two_slots: assert property (@(posedge bit_clk) disable iff (!hresetn)
		(en_l && word_end && wt_l == wt_ctrl_data && slot_r == 2'd1) |=> slot_r == 2'd0)
		else $error("two-word sequence did not wrap");
	a_rx_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		done_evt |=> rx_ready_r) else $error("received word flag lost");

	c_single_word: cover property (@(posedge bit_clk) disable iff (!hresetn) word_end && wt_l == wt_single);
	c_stereo_pair: cover property (@(posedge bit_clk) disable iff (!hresetn)
		state_r == st_wait_fall ##[1:200] word_end);
	c_three_wrap: cover property (@(posedge bit_clk) disable iff (!hresetn)
		word_end && wt_l == wt_ctrl_data2 && slot_r == 2'd2);
	c_delayed_start: cover property (@(posedge bit_clk) disable iff (!hresetn)
		state_r == st_delay ##1 state_r == st_shift);
endmodule

// file: rtl/codec_seq_pkg.sv
// constants, field layout and types shared by the codec frame sync sequencer
package codec_seq_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00; // codec_control_reg
	localparam logic [7:0] CLKCFG_OFS = 8'h04; // bit_clock_config_reg
	localparam logic [7:0] FRAME_OFS  = 8'h08; // first_bit_delay
	localparam logic [7:0] TXDATA_OFS = 8'h0c; // next word to send
	localparam logic [7:0] RXDATA_OFS = 8'h10; // last word received
	localparam logic [7:0] STATUS_OFS = 8'h14; // sequencer status

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_RUN_BIT    = 0; // sequencer enable
	localparam int CTRL_FSDIR_BIT  = 1; // frame_sync_direction_bit
	localparam int CTRL_WT_LO_BIT  = 2; // word_type_select_low
	localparam int CTRL_WT_HI_BIT  = 3; // word_type_select_high
	localparam int CTRL_WSIZE_BIT  = 4; // word_size_select, 1 = 32 bits
	localparam int CLK_SCDIR_BIT   = 0; // bit_clock_direction_bit
	localparam int CLK_TES_BIT     = 1; // tx_edge_select
	localparam int STAT_RXRDY_BIT  = 0; // received word waiting
	localparam int STAT_KIND_LO    = 1; // kind of last word, two bits
	localparam int STAT_BUSY_BIT   = 3; // link not idle
	localparam int STAT_OVR_BIT    = 4; // received word overwritten

	// ------------------------------------------------------------
	// reset values and counts
	// ------------------------------------------------------------
	localparam logic [4:0] CTRL_RST    = 5'h00;
	localparam logic [1:0] CLKCFG_RST  = 2'h0;
	localparam logic [7:0] DELAY_RST   = 8'h00;
	localparam logic [4:0] LAST_BIT_16 = 5'h0f;
	localparam logic [4:0] LAST_BIT_32 = 5'h1f;
	localparam logic       HRESP_OKAY  = 1'b0;

	typedef enum logic [1:0] {
		wt_single     = 2'b00,
		wt_ctrl_data  = 2'b01,
		wt_ctrl_data2 = 2'b10,
		wt_stereo     = 2'b11
	} word_type_e;

	typedef enum logic [1:0] {
		kind_data    = 2'b00,
		kind_control = 2'b01,
		kind_left    = 2'b10,
		kind_right   = 2'b11
	} word_kind_e;

	typedef enum logic [1:0] {
		st_idle      = 2'b00,
		st_delay     = 2'b01,
		st_shift     = 2'b10,
		st_wait_fall = 2'b11
	} link_state_e;

endpackage

// file: test/codec_model.sv
// behavioural codec that clocks frames into and out of the sequencer
`timescale 1ns/10ps
module codec_model (
	output logic      bit_clk,    // link clock, still between frames
	output logic      frame_sync, // frame sync level
	output logic      sdata_o,    // serial data towards the block
	input  wire logic sdata_i     // serial data from the block
);
	logic        run = 1'b0;
	logic [31:0] cap_rise;
	logic [31:0] cap_fall;

	// ------------------------------------------------------------
	// clock and capture
	// ------------------------------------------------------------
	// the offset keeps link edges off the bus clock edges
	initial begin
		bit_clk = 1'b0;
		frame_sync = 1'b0;
		sdata_o = 1'b0;
		#5;
		forever #32 if (run) bit_clk = ~bit_clk;
	end
	// both capture chains run all the time; a frame picks one afterwards
	always @(negedge bit_clk) cap_fall <= {cap_fall[30:0], sdata_i};
	always @(posedge bit_clk) cap_rise <= {cap_rise[30:0], sdata_i};

	// runs the clock for n cycles, then stops it low
	task automatic tick(input int n);
		run = 1'b1;
		repeat (n) @(negedge bit_clk);
		run = 1'b0;
	endtask

	// one word: frame sync edge, programmed delay, n bits msb first, end level
	task automatic frame(input logic s_lvl, input logic e_lvl, input int dly, input int n,
		input logic tx_edge_select, input logic [31:0] rxw, output logic [31:0] got);
		run = 1'b1;
		repeat (6) @(negedge bit_clk);
		frame_sync = s_lvl; // left word under a high level, right word after the fall
		repeat (3 + dly) @(posedge bit_clk);
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge bit_clk);
			sdata_o = rxw[i];
			@(posedge bit_clk);
		end
		@(negedge bit_clk);
		if (tx_edge_select)
			@(posedge bit_clk);
		#1;
		got = tx_edge_select ? cap_rise : cap_fall;
		sdata_o = ~sdata_o; // released line shows the inverse, not the last bit
		frame_sync = e_lvl;
		repeat (3) @(negedge bit_clk);
		run = 1'b0;
	endtask
endmodule

// file: test/testbench.sv
// self-checking bench for the codec frame sync sequencer
`timescale 1ns/10ps
module testbench
	import codec_seq_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout, hresp, fs_o, fs_oe, sout, bclk_oe, bclk, fs, sin;
	logic [31:0] hrdata;
	logic [31:0] rd;
	int          failures = 0;
	int          comparisons = 0;
	int          cycles = 0;

	always #20 hclk = ~hclk;

	codec_frame_sync_sequencer DUT (
		.hclk              (hclk),
		.hresetn           (hresetn),
		.clk_en            (1'b1),
		.hsel              (hsel),
		.haddr             (haddr),
		.htrans            (htrans),
		.hwrite            (hwrite),
		.hsize             (3'h2),
		.hwdata            (hwdata),
		.hready            (hreadyout),
		.hreadyout         (hreadyout),
		.hrdata            (hrdata),
		.hresp             (hresp),
		.bit_clk           (bclk),
		.frame_sync_pin_i  (fs),
		.frame_sync_pin_o  (fs_o),
		.frame_sync_pin_oe (fs_oe),
		.serial_in_pin     (sin),
		.serial_out_pin    (sout),
		.bit_clk_oe        (bclk_oe)
	);
	codec_model codec (
		.bit_clk    (bclk),
		.frame_sync (fs),
		.sdata_o    (sin),
		.sdata_i    (sout)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// a hang ends the run through the same report
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures++;
			close_out();
		end
	end

	// single ahb transfer; hreadyout is looked at mid-cycle, where it already
	// holds the value that the next rising edge samples
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(negedge hclk); while (hreadyout !== 1'b1);
		@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(negedge hclk); while (hreadyout !== 1'b1);
		@(posedge hclk);
		q = hrdata;
	endtask

	// run bit set, frame sync left as an input, bit clock as an input
	task automatic setup(input logic [1:0] wt, input logic w32, input logic [7:0] d, input logic tx_edge_select);
		bus(1'b1, CLKCFG_OFS, {30'h0, tx_edge_select, 1'b0}, rd);
		bus(1'b1, FRAME_OFS, {24'h0, d}, rd);
		bus(1'b1, CTRL_OFS, {27'h0, w32, wt, 2'b01}, rd);
	endtask

	// one word through the link, checked in both directions with its kind
	task automatic word(input logic s_lvl, input logic e_lvl, input logic [7:0] d, input logic w32,
		input logic tx_edge_select, input logic [31:0] tx, input logic [31:0] rxw, input logic [1:0] kind);
		logic [31:0] got;
		logic [31:0] mask;
		mask = w32 ? 32'hffffffff : 32'h0000ffff;
		bus(1'b1, TXDATA_OFS, tx, rd);
		codec.frame(s_lvl, e_lvl, int'(d), w32 ? 32 : 16, tx_edge_select, rxw, got);
		chk("serial out", got & mask, tx & mask);
		repeat (6) @(posedge hclk);
		bus(1'b0, STATUS_OFS, 32'h0, rd);
		chk("status kind", rd & 32'h7, {29'h0, kind, 1'b1});
		bus(1'b0, RXDATA_OFS, 32'h0, rd);
		chk("rx word", rd & mask, rxw & mask);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		bus(1'b0, CTRL_OFS, 32'h0, rd);
		chk("ctrl reset", rd, 32'h0);
		chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
		bus(1'b1, 8'h40, 32'hffffffff, rd);
		bus(1'b0, 8'h40, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		bus(1'b1, CTRL_OFS, 32'h2, rd);
		bus(1'b1, CLKCFG_OFS, 32'h1, rd);
		@(negedge hclk);
		chk("fs oe on", {31'h0, fs_oe}, 32'h1);
		chk("fs drive", {31'h0, fs_o}, 32'h0);
		chk("clk oe on", {31'h0, bclk_oe}, 32'h1);
		bus(1'b1, CTRL_OFS, 32'h0, rd);
		bus(1'b1, CLKCFG_OFS, 32'h0, rd);
		@(negedge hclk);
		chk("fs oe off", {31'h0, fs_oe}, 32'h0);
		chk("clk oe off", {31'h0, bclk_oe}, 32'h0);
	endtask

	// short, zero and longest delays, both word sizes and both transmit edges
	task automatic t_single;
		setup(wt_single, 1'b0, 8'h02, 1'b0);
		word(1'b1, 1'b0, 8'h02, 1'b0, 1'b0, 32'h0000a5c3, 32'h00003c69, kind_data);
		setup(wt_single, 1'b1, 8'h00, 1'b1);
		word(1'b1, 1'b0, 8'h00, 1'b1, 1'b1, 32'h8badf00d, 32'h13572468, kind_data);
		setup(wt_single, 1'b0, 8'hff, 1'b0);
		word(1'b1, 1'b0, 8'hff, 1'b0, 1'b0, 32'h00004e1d, 32'h0000b2c7, kind_data);
	endtask

	// the slot count wraps after two and after three words
	task automatic t_multi;
		setup(wt_ctrl_data, 1'b0, 8'h01, 1'b0);
		word(1'b1, 1'b0, 8'h01, 1'b0, 1'b0, 32'h00001e11, 32'h0000e001, kind_control);
		word(1'b1, 1'b0, 8'h01, 1'b0, 1'b0, 32'h00002d22, 32'h0000e002, kind_data);
		word(1'b1, 1'b0, 8'h01, 1'b0, 1'b0, 32'h00003c33, 32'h0000e003, kind_control);
		setup(wt_ctrl_data2, 1'b1, 8'h03, 1'b0);
		word(1'b1, 1'b0, 8'h03, 1'b1, 1'b0, 32'h11110001, 32'hc0de0001, kind_control);
		word(1'b1, 1'b0, 8'h03, 1'b1, 1'b0, 32'h22220002, 32'hc0de0002, kind_data);
		word(1'b1, 1'b0, 8'h03, 1'b1, 1'b0, 32'h33330003, 32'hc0de0003, kind_data);
		word(1'b1, 1'b0, 8'h03, 1'b1, 1'b0, 32'h44440004, 32'hc0de0004, kind_control);
	endtask

	task automatic t_stereo;
		setup(wt_stereo, 1'b0, 8'h04, 1'b0);
		word(1'b1, 1'b1, 8'h04, 1'b0, 1'b0, 32'h00009617, 32'h00005e83, kind_left);
		word(1'b0, 1'b0, 8'h04, 1'b0, 1'b0, 32'h0000c2d9, 32'h0000714b, kind_right);
	endtask

	// with the bit clock set as an output no word may run on a codec frame
	task automatic t_slave;
		bus(1'b1, CLKCFG_OFS, 32'h1, rd);
		codec.frame(1'b1, 1'b0, 0, 16, 1'b0, 32'h0000ffff, rd);
		repeat (6) @(posedge hclk);
		bus(1'b0, STATUS_OFS, 32'h0, rd);
		chk("slave no word", rd & 32'h19, 32'h0);
	endtask

	initial begin
		fork
			codec.tick(3);
			repeat (6) @(posedge hclk);
		join
		hresetn <= 1'b1;
		t_regs();
		t_single();
		t_multi();
		t_stereo();
		t_slave();
		close_out();
	end
endmodule
